// *** logic/macacc_pkg.sv ***
// constants and types of the accumulator result path
package macacc_pkg;
	localparam int ACC_W      = 40;
	localparam int WORD_W     = 16;
	localparam int GUARD_W    = 8;
	localparam int LOW_LSB    = 0;
	localparam int MID_LSB    = 16;
	localparam int GUARD_LSB  = 32;
	localparam int ROUND_BIT  = 15;
	localparam int EVEN_BIT   = 16;
	localparam int OVF_TOP    = 31;
	localparam logic [39:0] ACC_RESET   = 40'h00_0000_0000;
	localparam logic [15:0] FB_RESET    = 16'h0000;
	localparam logic [39:0] SAT_POS     = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT_NEG     = 40'hFF_8000_0000;
	localparam logic [39:0] ROUND_ADD   = 40'h00_0000_8000;

	typedef enum logic [2:0] {
		MACACC_OP_NONE,
		MACACC_OP_MUL,
		MACACC_OP_MAC_ADD,
		MACACC_OP_MAC_SUB,
		MACACC_OP_CLEAR,
		MACACC_OP_SAT
	} macacc_op_type;

	typedef enum logic [1:0] {
		MACACC_SEL_LOW,
		MACACC_SEL_MID,
		MACACC_SEL_GUARD,
		MACACC_SEL_NONE
	} macacc_sel_type;
endpackage

// *** logic/macacc_result.sv ***
// accumulator result register with overflow, saturation and rounding
`timescale 1ns/1ns
// Behaviour
// - result held as low word 0-15, middle word 16-31, guard byte 32-39
// - each section written from data bus, read onto data or result bus
// - guard byte read onto either bus is sign-extended to sixteen bits
// - middle word write fills guard byte with the middle word sign bit
// - every multiply/accumulate operation updates the overflow flag
// - overflow set when top nine result bits are not all equal
// - saturate looks only at overflow flag and guard byte sign bit
// - saturate: flag clear keeps value, else largest positive or most negative
// - saturation only by explicit instruction, never automatic
// - rounding requested rounds at boundary between bit 15 and 16
// - rounded value goes to feedback register or the accumulator
// - rounding adds one at bit 15, carry flows upward
// - exact midway forces bit 16 of rounded output to zero
// - functions: multiply, add, subtract, clear to zero
// - product sign-extended, shifted left one, zero-filled
// - feedback register takes bits 16 to 31 of the sum after rounding
// - reads show earlier cycle value; writes visible next cycle
module macacc_result (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    clockEnable,
	input  wire macacc_pkg::macacc_op_type opCode,
	input  wire logic [31:0]             product,
	input  wire logic                    roundEnable,
	input  wire logic                    toFeedback,
	input  wire logic [15:0]             dataBusIn,
	input  wire macacc_pkg::macacc_sel_type writeSel,
	input  wire macacc_pkg::macacc_sel_type dataReadSel,
	input  wire macacc_pkg::macacc_sel_type resultReadSel,
	output logic [15:0]                  dataBusOut,
	output logic [15:0]                  resultBusOut,
	output logic [15:0]                  feedbackRegister,
	output logic                         macOverflowFlag
);
	logic [39:0] accumulatorResult;
	logic [39:0] productAligned;
	logic [39:0] adderSum;
	logic [39:0] roundedSum;
	logic [39:0] finalSum;
	logic [39:0] saturated;
	logic        isMidway;
	logic        isArith;
	logic        nextOverflow;
	logic        isClear;
	logic        isSat;
	logic        writeLow;
	logic        writeMid;
	logic        writeGuard;
	logic        guardSign;
	logic [8:0]  topNine;
	logic [39:0] next_accumulator;

	function automatic logic [15:0] readSection(input logic [39:0] acc,
			input macacc_pkg::macacc_sel_type sel);
		unique case (sel)
			macacc_pkg::MACACC_SEL_LOW:   readSection = acc[15:0];
			macacc_pkg::MACACC_SEL_MID:   readSection = acc[31:16];
			macacc_pkg::MACACC_SEL_GUARD: readSection = {{8{acc[39]}}, acc[39:32]};
			macacc_pkg::MACACC_SEL_NONE:  readSection = 16'h0000;
		endcase
	endfunction

	assign productAligned = {{7{product[31]}}, product, 1'b0};
	assign isArith = (opCode == macacc_pkg::MACACC_OP_MUL) ||
			(opCode == macacc_pkg::MACACC_OP_MAC_ADD) ||
			(opCode == macacc_pkg::MACACC_OP_MAC_SUB);

	always_comb begin
		unique case (opCode)
			macacc_pkg::MACACC_OP_MAC_ADD: adderSum = accumulatorResult + productAligned;
			macacc_pkg::MACACC_OP_MAC_SUB: adderSum = accumulatorResult - productAligned;
			macacc_pkg::MACACC_OP_MUL:     adderSum = productAligned;
			default:                       adderSum = macacc_pkg::ACC_RESET;
		endcase
	end

	assign isMidway = adderSum[15] && (adderSum[14:0] == 15'h0000);
	assign roundedSum = adderSum + macacc_pkg::ROUND_ADD;
	assign finalSum = !roundEnable ? adderSum :
			{roundedSum[39:17], roundedSum[16] & ~isMidway, roundedSum[15:0]};
	assign topNine = finalSum[39:31];
	assign nextOverflow = !((topNine == 9'h1FF) || (topNine == 9'h000));
	assign guardSign = accumulatorResult[39];
	assign saturated = !macOverflowFlag ? accumulatorResult :
			(guardSign ? macacc_pkg::SAT_NEG : macacc_pkg::SAT_POS);

	assign isClear = (opCode == macacc_pkg::MACACC_OP_CLEAR);
	assign isSat = (opCode == macacc_pkg::MACACC_OP_SAT);
	assign writeLow = (writeSel == macacc_pkg::MACACC_SEL_LOW);
	assign writeMid = (writeSel == macacc_pkg::MACACC_SEL_MID);
	assign writeGuard = (writeSel == macacc_pkg::MACACC_SEL_GUARD);

	assign dataBusOut = readSection(accumulatorResult, dataReadSel);
	assign resultBusOut = readSection(accumulatorResult, resultReadSel);

	// section writes override the operation result
	always_comb begin
		next_accumulator = accumulatorResult;
		if (isArith && !toFeedback)
			next_accumulator = finalSum;
		else if (isClear)
			next_accumulator = macacc_pkg::ACC_RESET;
		else if (isSat)
			next_accumulator = saturated;
		if (writeLow)
			next_accumulator[15:0] = dataBusIn;
		if (writeMid)
			next_accumulator[39:16] = {{8{dataBusIn[15]}}, dataBusIn};
		if (writeGuard)
			next_accumulator[39:32] = dataBusIn[7:0];
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			accumulatorResult <= macacc_pkg::ACC_RESET;
		else if (clockEnable)
			accumulatorResult <= next_accumulator;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			feedbackRegister <= macacc_pkg::FB_RESET;
		else if (clockEnable && isArith && toFeedback)
			feedbackRegister <= finalSum[31:16];
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			macOverflowFlag <= 1'b0;
		else if (clockEnable && isArith)
			macOverflowFlag <= nextOverflow;
	end

	a_overflow_update: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isArith |=> macOverflowFlag == $past(nextOverflow))
		else $error("overflow flag not updated by operation");
	a_midway_even: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && roundEnable && isMidway |-> finalSum[16] == 1'b0)
		else $error("midway rounding not even");
	a_sat_positive: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && opCode == macacc_pkg::MACACC_OP_SAT && macOverflowFlag
		&& !accumulatorResult[39] && writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> accumulatorResult == macacc_pkg::SAT_POS)
		else $error("positive saturation wrong");
	a_sat_hold: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && opCode == macacc_pkg::MACACC_OP_SAT && !macOverflowFlag
		&& writeSel == macacc_pkg::MACACC_SEL_NONE |=> $stable(accumulatorResult))
		else $error("saturation changed value without overflow");
	a_mid_extend: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && writeSel == macacc_pkg::MACACC_SEL_MID
		|=> accumulatorResult[39:32] == {8{$past(dataBusIn[15])}})
		else $error("guard byte not sign extended");
	a_guard_read: assert property (@(posedge clock) disable iff (!rst_n)
		dataReadSel == macacc_pkg::MACACC_SEL_GUARD |-> dataBusOut[15:8] == {8{dataBusOut[7]}})
		else $error("guard byte read not sign extended");
	a_feedback_take: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isArith && toFeedback && writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> feedbackRegister == $past(finalSum[31:16]) && $stable(accumulatorResult))
		else $error("feedback capture wrong");
	a_no_autosat: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && opCode == macacc_pkg::MACACC_OP_MAC_ADD && !toFeedback
		&& writeSel == macacc_pkg::MACACC_SEL_NONE |=> accumulatorResult == $past(finalSum))
		else $error("accumulation altered");

	a_freeze_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!clockEnable |=> $stable(accumulatorResult) && $stable(feedbackRegister)
		&& $stable(macOverflowFlag))
		else $error("state changed while clock enable low");

	a_clear_zero: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isClear && writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> accumulatorResult == macacc_pkg::ACC_RESET)
		else $error("clear did not zero accumulator");

	a_clear_flag: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isClear |=> $stable(macOverflowFlag))
		else $error("clear changed overflow flag");

	a_sat_negative: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isSat && macOverflowFlag && accumulatorResult[39]
		&& writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> accumulatorResult == macacc_pkg::SAT_NEG)
		else $error("negative saturation wrong");

	a_sat_flag: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isSat |=> $stable(macOverflowFlag))
		else $error("saturate changed overflow flag");

	a_mul_load: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && opCode == macacc_pkg::MACACC_OP_MUL && !roundEnable && !toFeedback
		&& writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> accumulatorResult == {{7{$past(product[31])}}, $past(product), 1'b0})
		else $error("product alignment wrong");

	a_sub_result: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && opCode == macacc_pkg::MACACC_OP_MAC_SUB && !roundEnable && !toFeedback
		&& writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> accumulatorResult == $past(accumulatorResult)
		- {{7{$past(product[31])}}, $past(product), 1'b0})
		else $error("subtract result wrong");

	a_flag_value: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isArith && !toFeedback && writeSel == macacc_pkg::MACACC_SEL_NONE
		|=> macOverflowFlag == !(accumulatorResult[39:31] == 9'h1FF
		|| accumulatorResult[39:31] == 9'h000))
		else $error("overflow flag disagrees with result");

	a_low_write: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && writeLow |=> accumulatorResult[15:0] == $past(dataBusIn))
		else $error("low word write lost");

	a_mid_write: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && writeMid |=> accumulatorResult[31:16] == $past(dataBusIn))
		else $error("middle word write lost");

	a_guard_write: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && writeGuard |=> accumulatorResult[39:32] == $past(dataBusIn[7:0]))
		else $error("guard byte write lost");

	a_round_carry: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && isArith && roundEnable && !isMidway
		|-> finalSum == adderSum + macacc_pkg::ROUND_ADD)
		else $error("rounding carry wrong");

	a_result_read: assert property (@(posedge clock) disable iff (!rst_n)
		resultReadSel == macacc_pkg::MACACC_SEL_GUARD
		|-> resultBusOut == {{8{accumulatorResult[39]}}, accumulatorResult[39:32]})
		else $error("guard byte result bus read wrong");

	a_read_none: assert property (@(posedge clock) disable iff (!rst_n)
		dataReadSel == macacc_pkg::MACACC_SEL_NONE |-> dataBusOut == 16'h0000)
		else $error("idle data bus read not zero");

	a_feedback_hold: assert property (@(posedge clock) disable iff (!rst_n)
		clockEnable && !(isArith && toFeedback) |=> $stable(feedbackRegister))
		else $error("feedback register changed without capture");
endmodule // macacc_result

// *** verif/macacc_decoder_model.sv ***
// decoder and data bus model driving the accumulator path
`timescale 1ns/1ns
module macacc_decoder_model (
	input  wire logic                  clock,
	output macacc_pkg::macacc_op_type  opCode,
	output logic [31:0]                product,
	output logic                       roundEnable,
	output logic                       toFeedback,
	output logic [15:0]                dataBusIn,
	output macacc_pkg::macacc_sel_type writeSel
);
	// one instruction for one cycle, then idle with stale bus values inverted
	task automatic issue(input logic [2:0] op, input logic [31:0] p, input logic [1:0] fl,
			input logic [15:0] d, input logic [1:0] ws);
		@(posedge clock);
		#1;
		opCode = macacc_pkg::macacc_op_type'(op);
		product = p;
		{roundEnable, toFeedback} = fl;
		dataBusIn = d;
		writeSel = macacc_pkg::macacc_sel_type'(ws);
		@(posedge clock);
		#1;
		opCode = macacc_pkg::MACACC_OP_NONE;
		writeSel = macacc_pkg::MACACC_SEL_NONE;
		dataBusIn = ~d;
		product = ~p;
	endtask
	initial issue(3'h0, 32'h0, 2'h0, 16'h0, 2'h3);
endmodule // macacc_decoder_model

// *** verif/tb_top.sv ***
// self-checking bench for the accumulator result path
`timescale 1ns/1ns
module tb_top;
	logic                       clock = 0;
	logic                       rst_n = 0;
	logic                       clockEnable = 1;
	macacc_pkg::macacc_op_type  opCode;
	macacc_pkg::macacc_sel_type writeSel;
	macacc_pkg::macacc_sel_type dataReadSel = macacc_pkg::MACACC_SEL_NONE;
	macacc_pkg::macacc_sel_type resultReadSel = macacc_pkg::MACACC_SEL_NONE;
	logic [31:0]                product;
	logic                       roundEnable, toFeedback;
	logic [15:0]                dataBusIn, dataBusOut, resultBusOut, feedbackRegister;
	logic                       macOverflowFlag;
	int                         mismatches = 0;
	int                         n_checks = 0;
	always #5 clock = ~clock;
	macacc_result macacc_result_i (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
		.opCode(opCode), .product(product), .roundEnable(roundEnable), .toFeedback(toFeedback),
		.dataBusIn(dataBusIn), .writeSel(writeSel), .dataReadSel(dataReadSel),
		.resultReadSel(resultReadSel), .dataBusOut(dataBusOut), .resultBusOut(resultBusOut),
		.feedbackRegister(feedbackRegister), .macOverflowFlag(macOverflowFlag));
	macacc_decoder_model macacc_decoder_model_i (.clock(clock), .opCode(opCode),
		.product(product), .roundEnable(roundEnable), .toFeedback(toFeedback),
		.dataBusIn(dataBusIn), .writeSel(writeSel));
	task automatic cmp(input logic [15:0] got, input logic [15:0] want);
		n_checks++;
		if (got !== want) begin
			mismatches++;
			$display("MISMATCH %0t got %h want %h", $time, got, want);
		end
	endtask
	// all three sections on both read buses, guard sign-extended
	task automatic chk(input logic [39:0] e, input logic f);
		logic [15:0] w [3];
		w = '{e[15:0], e[31:16], {{8{e[39]}}, e[39:32]}};
		for (int i = 0; i < 3; i++) begin
			dataReadSel = macacc_pkg::macacc_sel_type'(i);
			resultReadSel = dataReadSel;
			#1;
			cmp(dataBusOut, w[i]);
			cmp(resultBusOut, w[i]);
		end
		dataReadSel = macacc_pkg::MACACC_SEL_NONE;
		resultReadSel = macacc_pkg::MACACC_SEL_NONE;
		#1;
		cmp(dataBusOut, 16'h0000);
		cmp(resultBusOut, 16'h0000);
		cmp({15'h0, macOverflowFlag}, {15'h0, f});
	endtask
	task automatic t_sections;
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h1234, 2'h0);
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h8000, 2'h1);
		chk(40'hFF_8000_1234, 1'b0);
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h0005, 2'h2);
		chk(40'h05_8000_1234, 1'b0);
	endtask
	task automatic t_overflow_sat;
		macacc_decoder_model_i.issue(3'h4, 32'h0, 2'h0, 16'h0, 2'h3);
		chk(40'h00_0000_0000, 1'b0);
		macacc_decoder_model_i.issue(3'h2, 32'h4000_0000, 2'h0, 16'h0, 2'h3);
		chk(40'h00_8000_0000, 1'b1);
		macacc_decoder_model_i.issue(3'h2, 32'h4000_0000, 2'h0, 16'h0, 2'h3);
		chk(40'h01_0000_0000, 1'b1);
		macacc_decoder_model_i.issue(3'h5, 32'h0, 2'h0, 16'h0, 2'h3);
		chk(40'h00_7FFF_FFFF, 1'b1);
		macacc_decoder_model_i.issue(3'h1, 32'hFFFF_FFFF, 2'h0, 16'h0, 2'h3);
		chk(40'hFF_FFFF_FFFE, 1'b0);
		macacc_decoder_model_i.issue(3'h3, 32'h4000_0000, 2'h0, 16'h0, 2'h3);
		chk(40'hFF_7FFF_FFFE, 1'b1);
		macacc_decoder_model_i.issue(3'h5, 32'h0, 2'h0, 16'h0, 2'h3);
		chk(40'hFF_8000_0000, 1'b1);
		macacc_decoder_model_i.issue(3'h1, 32'h0000_0001, 2'h0, 16'h0, 2'h3);
		macacc_decoder_model_i.issue(3'h5, 32'h0, 2'h0, 16'h0, 2'h3);
		chk(40'h00_0000_0002, 1'b0);
	endtask
	task automatic t_round;
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h0002, 2'h1);
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h8000, 2'h0);
		macacc_decoder_model_i.issue(3'h2, 32'h0, 2'h2, 16'h0, 2'h3);
		chk(40'h00_0002_0000, 1'b0);
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h8001, 2'h0);
		macacc_decoder_model_i.issue(3'h2, 32'h0, 2'h3, 16'h0, 2'h3);
		cmp(feedbackRegister, 16'h0003);
		chk(40'h00_0002_8001, 1'b0);
	endtask
	task automatic t_freeze;
		clockEnable = 0;
		macacc_decoder_model_i.issue(3'h0, 32'h0, 2'h0, 16'h7FFF, 2'h1);
		macacc_decoder_model_i.issue(3'h2, 32'h4000_0000, 2'h1, 16'h0, 2'h3);
		clockEnable = 1;
		chk(40'h05_8000_1234, 1'b0);
		cmp(feedbackRegister, 16'h0000);
	endtask
	task automatic t_reset;
		macacc_decoder_model_i.issue(3'h2, 32'h4000_0000, 2'h0, 16'h0, 2'h3);
		chk(40'h00_8002_8001, 1'b1);
		@(posedge clock);
		#1;
		rst_n = 0;
		@(posedge clock);
		#1;
		rst_n = 1;
		chk(40'h00_0000_0000, 1'b0);
		cmp(feedbackRegister, 16'h0000);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		#1;
		rst_n = 1;
		t_sections();
		t_freeze();
		t_overflow_sat();
		t_round();
		t_reset();
		final_report();
	end
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
endmodule // tb_top
